/* verilog/rcsr_top.sv */
`timescale 1ns/1ps
// How it works
// [RQ1] N cells form an N-bit binary counter from zero to all ones.
// [RQ2] Count pulse toggles cell 0; each cell output triggers the next.
// [RQ3] Stage changes only on rising trigger; next advances on one-to-zero.
// [RQ4] Each next stage changes once per two changes of its predecessor.
// [RQ5] Reset pulse clears every stage before counting.
// [RQ6] Four stages read all ones after fifteen pulses from zero.
// [RQ7] Driver keeps set/reset enables primed or inhibited until due.
// [RQ8] Load in parallel or serially; shift out serially either way.
// [RQ9] On shift pulse each cell captures its two level inputs; rcsr_cell reads set_lvl only and leaves reset_lvl unused.
// [RQ10] Driver gives complementary set and reset level inputs.
// [RQ11] Cell toggles when stored differs from incoming, else holds.
// [RQ12] Chained cell: set from previous complement, reset from previous true.
// [RQ13] Serial source supplies both polarities, crossed like between cells.
// [RQ14] Parallel: reset from source true, set from source complement.
// [RQ15] Separate serial and parallel shift pulses with own gate pairs.
// [RQ16] All cells shift together using predecessor's pre-pulse value.
// [RQ17] Group controls clear or set all cells at once.
// [RQ18] Per-cell direct overrides force one or zero, held safely.
// [RQ19] Pulses detected as rising edges of the system clock.
module rcsr_top #(
   parameter int WIDTH = rcsr_pkg::RCSR_WIDTH
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire rcsr_pkg::rcsr_mode_t mode,
   input wire rcsr_pkg::rcsr_pulse_t pulses,
   input wire rcsr_pkg::rcsr_serial_t serial_in,
   input wire logic [WIDTH-1:0] par_true,
   input wire logic [WIDTH-1:0] par_comp,
   input wire logic group_set,
   input wire logic group_reset,
   input wire logic [WIDTH-1:0] force_one,
   input wire logic [WIDTH-1:0] force_zero,
   output logic [WIDTH-1:0] cells_q,
   output logic [WIDTH-1:0] cells_n_q,
   output logic serial_out_q
);
   import rcsr_pkg::*;

   rcsr_pulse_t pulses_q;
   logic count_rise;
   logic ser_rise;
   logic par_rise;
   logic is_shift;
   logic [WIDTH-1:0] bits;
   logic [WIDTH-1:0] trig;
   logic [WIDTH-1:0] tog;
   logic [WIDTH-1:0] set_in;
   logic [WIDTH-1:0] rst_in;
   logic [WIDTH-1:0] next_bits;

   // Previous pulse levels for edge detection
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pulses_q <= '0;
      end else begin
         pulses_q <= pulses; // RQ19
      end
   end

   assign is_shift = (mode == RCSR_MODE_SHIFT);
   // Undefined mode codes ignore counted pulses as well as shifts
   assign count_rise = pulses.count_pulse & ~pulses_q.count_pulse
      & (mode == RCSR_MODE_COUNT); // RQ19
   assign ser_rise = pulses.serial_shift & ~pulses_q.serial_shift & is_shift; // RQ19
   assign par_rise = pulses.parallel_shift & ~pulses_q.parallel_shift & is_shift & ~ser_rise;

   // Ripple collapsed into one cycle: stage k toggles when all lower stages fall
   always_comb begin
      trig[0] = count_rise; // RQ2
      for (int k = 1; k < WIDTH; k++) begin
         trig[k] = trig[k-1] & bits[k-1]; // RQ3 RQ4
      end
      tog = trig; // RQ1 RQ6
   end

   // Level inputs taken from pre-pulse state of the chain, or from par_comp/par_true on a parallel shift
   always_comb begin
      if (par_rise) begin
         set_in = par_comp; // RQ14
         rst_in = par_true; // RQ14
      end else begin
         set_in = {~bits[WIDTH-2:0], serial_in.set_lvl}; // RQ12 RQ13
         rst_in = {bits[WIDTH-2:0], serial_in.reset_lvl}; // RQ12 RQ16
      end
   end

   for (genvar i = 0; i < WIDTH; i++) begin : g_cell
      rcsr_cell u_cell (
         .core_clk(core_clk),
         .rst(rst), // RQ5
         .toggle_en(tog[i]),
         .load_en(ser_rise | par_rise), // RQ9 RQ11 RQ15
         .set_lvl(set_in[i]),
         .reset_lvl(rst_in[i]),
         .group_set(group_set), // RQ17
         .group_reset(group_reset), // RQ17
         .force_one(force_one[i]), // RQ18
         .force_zero(force_zero[i]), // RQ18
         .bit_q(bits[i])
      );
   end

   assign cells_q = bits;

   // Complement and serial tap registered from the same next values
   always_ff @(posedge core_clk) begin
      if (rst) begin
         cells_n_q <= '1;
         serial_out_q <= 1'b0;
      end else begin
         cells_n_q <= ~next_bits;
         serial_out_q <= next_bits[WIDTH-1]; // RQ8
      end
   end

   always_comb begin
      next_bits = bits;
      for (int k = 0; k < WIDTH; k++) begin
         if (tog[k]) begin
            next_bits[k] = ~bits[k];
         end
         if (ser_rise | par_rise) begin
            if (bits[k] && set_in[k]) begin
               next_bits[k] = 1'b0;
            end else if (!bits[k] && !set_in[k]) begin
               next_bits[k] = 1'b1;
            end
         end
         if (group_reset || force_zero[k]) begin
            next_bits[k] = 1'b0;
         end else if (group_set || force_one[k]) begin
            next_bits[k] = 1'b1;
         end
      end
   end

   // Assertions
   count_step_a: assert property (@(posedge core_clk) disable iff (rst) // RQ1
      count_rise && !group_set && !group_reset && force_one == '0 && force_zero == '0
      |=> cells_q == $past(cells_q) + 1'b1)
      else $error("counter did not advance by one");
   count_hold_a: assert property (@(posedge core_clk) disable iff (rst) // RQ3
      !count_rise && !ser_rise && !par_rise && !group_set && !group_reset
      && force_one == '0 && force_zero == '0 |=> $stable(cells_q))
      else $error("cells changed without a pulse");
   reset_clear_a: assert property (@(posedge core_clk) rst |=> cells_q == '0) // RQ5
      else $error("reset did not clear cells");
   serial_shift_a: assert property (@(posedge core_clk) disable iff (rst) // RQ16
      ser_rise && !group_set && !group_reset && force_one == '0 && force_zero == '0
      |=> cells_q == {$past(cells_q[WIDTH-2:0]), $past(serial_in.reset_lvl)})
      else $error("serial shift wrong");
   par_load_a: assert property (@(posedge core_clk) disable iff (rst) // RQ14
      par_rise && !group_set && !group_reset && force_one == '0 && force_zero == '0
      |=> cells_q == $past(par_true))
      else $error("parallel load wrong");
   group_reset_a: assert property (@(posedge core_clk) group_reset |=> cells_q == '0) // RQ17
      else $error("group reset failed");
   group_set_a: assert property (@(posedge core_clk) disable iff (rst) // RQ17
      group_set && !group_reset && force_zero == '0 |=> cells_q == '1)
      else $error("group set failed");
   force_bit_a: assert property (@(posedge core_clk) disable iff (rst) // RQ18
      force_zero[0] |=> !cells_q[0])
      else $error("force zero failed");
   comp_out_a: assert property (@(posedge core_clk) disable iff (rst) // RQ12
      cells_n_q == ~cells_q)
      else $error("complement mismatch");
   serial_tap_a: assert property (@(posedge core_clk) disable iff (rst) // RQ8
      serial_out_q == cells_q[WIDTH-1])
      else $error("serial tap mismatch");
   edge_only_a: assert property (@(posedge core_clk) disable iff (rst) // RQ19
      pulses_q.count_pulse && pulses.count_pulse |-> !count_rise)
      else $error("level treated as edge");
   wrap_c: cover property (@(posedge core_clk) cells_q == RCSR_FULL ##1 cells_q == RCSR_CLEAR);
   ser_c: cover property (@(posedge core_clk) ser_rise);
   par_c: cover property (@(posedge core_clk) par_rise);
endmodule

/* inc/rcsr_pkg.sv */
package rcsr_pkg;
   localparam int RCSR_WIDTH = 4;
   localparam logic [RCSR_WIDTH-1:0] RCSR_CLEAR = 4'h0;
   localparam logic [RCSR_WIDTH-1:0] RCSR_FULL = 4'hf;

   typedef enum logic [1:0] {
      RCSR_MODE_COUNT = 2'b00,
      RCSR_MODE_SHIFT = 2'b01
   } rcsr_mode_t;

   // One group of pulse inputs, raw levels
   typedef struct packed {
      logic count_pulse;
      logic serial_shift;
      logic parallel_shift;
   } rcsr_pulse_t;

   // Complementary serial input pair
   typedef struct packed {
      logic set_lvl;
      logic reset_lvl;
   } rcsr_serial_t;
endpackage

/* verilog/rcsr_cell.sv */
`timescale 1ns/1ps
module rcsr_cell (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic toggle_en,
   input wire logic load_en,
   input wire logic set_lvl,
   input wire logic reset_lvl,
   input wire logic group_set,
   input wire logic group_reset,
   input wire logic force_one,
   input wire logic force_zero,
   output logic bit_q
);
   logic bit_d;

   always_comb begin
      bit_d = bit_q;
      if (toggle_en) begin
         bit_d = ~bit_q;
      end
      // Toggle when stored bit differs from incoming; set side carries complement
      if (load_en) begin
         if (bit_q && set_lvl) begin
            bit_d = 1'b0;
         end else if (!bit_q && !set_lvl) begin
            bit_d = 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst || group_reset || force_zero) begin
         bit_q <= 1'b0;
      end else if (group_set || force_one) begin
         bit_q <= 1'b1;
      end else begin
         bit_q <= bit_d;
      end
   end
endmodule

/* bench/rcsr_src_model.sv */
`timescale 1ns/1ps
// Source register and serial gate feeding the shift chain
module rcsr_src_model (
   input wire logic [rcsr_pkg::RCSR_WIDTH-1:0] src_val,
   input wire logic data_bit,
   output logic [rcsr_pkg::RCSR_WIDTH-1:0] par_true,
   output logic [rcsr_pkg::RCSR_WIDTH-1:0] par_comp,
   output rcsr_pkg::rcsr_serial_t serial_in
);
   import rcsr_pkg::*;
   assign par_true = src_val;
   assign par_comp = ~src_val;
   // Crossed like the links between cells
   assign serial_in.reset_lvl = data_bit;
   assign serial_in.set_lvl = ~data_bit;
endmodule

/* bench/tb_rcsr_top.sv */
`timescale 1ns/1ps
module tb_rcsr_top;
   import rcsr_pkg::*;
   logic core_clk, rst, group_set, group_reset, data_bit, serial_out_q;
   rcsr_mode_t mode;
   rcsr_pulse_t pulses;
   rcsr_serial_t serial_in;
   logic [RCSR_WIDTH-1:0] src_val, par_true, par_comp, force_one, force_zero;
   logic [RCSR_WIDTH-1:0] cells_q, cells_n_q, exp_q;
   int num_errors = 0;
   int total_checks = 0;
   rcsr_src_model i_src (.src_val(src_val), .data_bit(data_bit), .par_true(par_true),
      .par_comp(par_comp), .serial_in(serial_in));
   rcsr_top #(.WIDTH(RCSR_WIDTH)) i_dut (.core_clk(core_clk), .rst(rst), .mode(mode),
      .pulses(pulses), .serial_in(serial_in), .par_true(par_true), .par_comp(par_comp),
      .group_set(group_set), .group_reset(group_reset), .force_one(force_one),
      .force_zero(force_zero), .cells_q(cells_q), .cells_n_q(cells_n_q),
      .serial_out_q(serial_out_q));
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   task automatic check(input logic [RCSR_WIDTH-1:0] seen, input logic [RCSR_WIDTH-1:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic check_cells(input logic [RCSR_WIDTH-1:0] exp);
      check(cells_q, exp);
      check(cells_n_q, ~exp);
      check({{(RCSR_WIDTH-1){1'b0}}, serial_out_q}, {{(RCSR_WIDTH-1){1'b0}}, exp[RCSR_WIDTH-1]});
   endtask
   // Which: 2 count, 1 serial, 0 parallel; low gap keeps edges apart
   task automatic pulse(input int which);
      @(negedge core_clk);
      pulses = rcsr_pulse_t'(3'h1 << which);
      @(negedge core_clk);
      pulses = '0;
      @(negedge core_clk);
   endtask
   task automatic count_test;
      mode = RCSR_MODE_COUNT;
      for (int i = 1; i <= 16; i++) begin
         pulse(2);
         check_cells(4'(i));
      end
      pulse(1);
      check_cells(RCSR_CLEAR);
   endtask
   task automatic shift_test;
      mode = RCSR_MODE_SHIFT;
      exp_q = RCSR_CLEAR;
      foreach (src_val[i]) begin
         data_bit = 1'(4'hb >> i);
         pulse(1);
         exp_q = {exp_q[RCSR_WIDTH-2:0], data_bit};
         check_cells(exp_q);
      end
      pulse(2);
      check_cells(exp_q);
   endtask
   task automatic par_test;
      src_val = 4'h6;
      pulse(0);
      check_cells(4'h6);
      data_bit = 1'b1;
      pulse(1);
      check_cells(4'hd);
   endtask
   task automatic override_test;
      @(negedge core_clk);
      group_set = 1'b1;
      @(negedge core_clk);
      check_cells(RCSR_FULL);
      group_reset = 1'b1;
      @(negedge core_clk);
      check_cells(RCSR_CLEAR);
      {group_set, group_reset, force_one} = {2'b00, 4'h5};
      repeat (3) @(negedge core_clk);
      check_cells(4'h5);
      force_zero = 4'h1;
      @(negedge core_clk);
      {force_one, force_zero} = '0;
      @(negedge core_clk);
      check_cells(4'h4);
      rst = 1'b1;
      @(negedge core_clk);
      rst = 1'b0;
      check_cells(RCSR_CLEAR);
   endtask
   task automatic wrap_up;
      if (num_errors == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // About 85 cycles of tests; generous margin
   initial begin
      #(1000 * 50);
      num_errors++;
      wrap_up();
   end
   initial begin
      {rst, group_set, group_reset, data_bit} = 4'h8;
      {mode, pulses, src_val, force_one, force_zero} = '0;
      repeat (4) @(negedge core_clk);
      rst = 1'b0;
      check_cells(RCSR_CLEAR);
      count_test();
      shift_test();
      par_test();
      override_test();
      wrap_up();
   end
endmodule
